// *** srpf_defs.svh ***
// Purpose: constants for the sensor reply packet framer
// Assumes: one 10 MHz clock, byte-wide reply stream
// Notes: header codes are arbitrary but distinct per message type
`ifndef SRPF_DEFS_SVH
`define SRPF_DEFS_SVH
`define SRPF_HDR_IMAGE 8'hA1
`define SRPF_HDR_HIST 8'hA2
`define SRPF_HDR_AUTH 8'hA3
`define SRPF_HDR_REG 8'hA4
`define SRPF_HDR_FLASH 8'hA5
`define SRPF_HDR_NAV 8'hA6
`define SRPF_COLS 8'h80
`define SRPF_ROWS 4'h8
`define SRPF_BIN_MAX 8'h80
`define SRPF_NUM_REGS 4'h8
`define SRPF_REG_MASK0 8'hFF
`define SRPF_REG_MASK1 8'h0F
`define SRPF_FBUF_DEPTH 512
`endif

// *** srpf_pkg.sv ***
// Purpose: types for the sensor reply packet framer
// Assumes: nothing beyond the header
// Notes: none
`default_nettype none
package srpf_pkg;
   typedef enum logic [1:0] {
      SRPF_DEPTH_BIN = 2'b00,
      SRPF_DEPTH_G2 = 2'b01,
      SRPF_DEPTH_G4 = 2'b10
   } srpf_depth_t;
   typedef enum logic [3:0] {
      SRPF_IDLE = 4'b0000,
      SRPF_IMG_HDR = 4'b0001,
      SRPF_IMG_COL = 4'b0010,
      SRPF_HIST_HDR = 4'b0011,
      SRPF_HIST_BIN = 4'b0100,
      SRPF_AUTH_HDR = 4'b0101,
      SRPF_AUTH_DAT = 4'b0110,
      SRPF_REG_HDR = 4'b0111,
      SRPF_REG_PAIR = 4'b1000,
      SRPF_FL_HDR = 4'b1001,
      SRPF_FL_DAT = 4'b1010,
      SRPF_NAV_HDR = 4'b1011,
      SRPF_NAV_DAT = 4'b1100
   } srpf_state_t;
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } srpf_byte_t;
endpackage : srpf_pkg
`default_nettype wire

// *** srpf_framer.sv ***
// Purpose: builds header-prefixed reply messages onto a byte stream
// Assumes: pixel, flash and nav sources hold data until taken
// Notes: two-entry output buffer absorbs stalls from the usb side
// Overview of operation
// - every message but the flash reply starts with a single header byte
// - image header, then columns of 1, 2 or 4 bytes by pixel depth
// - a frame is 128 columns of 8 pixels
// - one histogram per image when enabled, none otherwise
// - histogram bins go out in order starting at value zero
// - no bin count ever exceeds 128
// - authentication word message follows the last image data
// - register read returns every register, address before value
// - unused register bits read as zero
// - register write takes address byte and data byte together in one cycle
// - flash reply carries a two-byte header before flash bytes
// - navigation mode sends compact nav packets instead of images
// - flash bytes are gathered in a 512-byte frame buffer
// - host flash commands pass through unchanged to the flash port
`include "srpf_defs.svh"
`default_nettype none
module srpf_framer (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic START_IMAGE,
   input wire logic NAV_MODE,
   input wire logic HIST_EN,
   input wire logic [1:0] PIX_DEPTH,
   input wire logic [31:0] COL_DATA,
   output logic [6:0] COL_INDEX,
   input wire logic [31:0] AUTH_WORD,
   input wire logic [15:0] NAV_DATA,
   input wire logic REG_READ,
   input wire logic REG_WR_VALID,
   input wire logic [7:0] REG_WR_ADDR,
   input wire logic [7:0] REG_WR_DATA,
   output logic [63:0] REG_FILE,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_BYTE,
   output logic FLASH_CMD_VALID,
   output logic [7:0] FLASH_CMD_BYTE,
   input wire logic FLASH_RD_START,
   input wire logic [8:0] FLASH_RD_LEN,
   input wire logic FLASH_IN_VALID,
   input wire logic [7:0] FLASH_IN_BYTE,
   output logic FLASH_IN_READY,
   output logic [7:0] OUT_DATA,
   output logic OUT_LAST,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic BUSY
);
   srpf_pkg::srpf_state_t state_reg;
   srpf_pkg::srpf_byte_t src_byte;
   logic src_valid;
   logic src_ready;
   logic [8:0] cnt_reg;
   logic [1:0] sub_reg;
   logic [7:0] hist_reg [0:15];
   logic [7:0] fbuf [0:`SRPF_FBUF_DEPTH-1];
   logic [8:0] fwr_reg;
   logic [8:0] flen_reg;
   logic fill_reg;
   logic [1:0] depth_reg;
   logic hist_en_reg;
   logic [7:0] regs_reg [0:7];
   logic [3:0] nbins;
   logic [2:0] col_bytes;
   logic take;
   logic [7:0] col_byte;
   logic [7:0] flash_byte;

   assign take = src_valid && src_ready;
   assign nbins = (depth_reg == srpf_pkg::SRPF_DEPTH_G4) ? 4'hF :
      (depth_reg == srpf_pkg::SRPF_DEPTH_G2) ? 4'h3 : 4'h1;
   assign col_bytes = (depth_reg == srpf_pkg::SRPF_DEPTH_G4) ? 3'h4 :
      (depth_reg == srpf_pkg::SRPF_DEPTH_G2) ? 3'h2 : 3'h1;
   assign col_byte = COL_DATA[{sub_reg, 3'h0} +: 8];
   assign COL_INDEX = cnt_reg[6:0];
   assign BUSY = (state_reg != srpf_pkg::SRPF_IDLE) || fill_reg;
   assign flash_byte = fbuf[cnt_reg];

   // host commands for the flash go straight through
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         FLASH_CMD_VALID <= 1'b0;
         FLASH_CMD_BYTE <= 8'h00;
      end
      else
      begin
         FLASH_CMD_VALID <= CMD_VALID;
         FLASH_CMD_BYTE <= CMD_BYTE;
      end
   end

   // register file; only low nibble of odd registers is implemented
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_reg
         always_ff @(posedge SYS_CLK or negedge RST_N)
         begin
            if (!RST_N)
               regs_reg[gi] <= 8'h00;
            else if (REG_WR_VALID && REG_WR_ADDR == 8'(gi))
               regs_reg[gi] <= REG_WR_DATA &
                  ((gi % 2 == 1) ? `SRPF_REG_MASK1 : `SRPF_REG_MASK0);
         end
         assign REG_FILE[gi*8 +: 8] = regs_reg[gi];
      end
   endgenerate

   // flash fill into frame buffer before the reply goes out
   assign FLASH_IN_READY = fill_reg;
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         fill_reg <= 1'b0;
         fwr_reg <= 9'h000;
         flen_reg <= 9'h000;
      end
      else if (FLASH_RD_START && !fill_reg && state_reg == srpf_pkg::SRPF_IDLE)
      begin
         fill_reg <= (FLASH_RD_LEN != 9'h000);
         fwr_reg <= 9'h000;
         flen_reg <= FLASH_RD_LEN;
      end
      else if (fill_reg && FLASH_IN_VALID)
      begin
         fwr_reg <= fwr_reg + 9'h001;
         if (fwr_reg + 9'h001 == flen_reg)
            fill_reg <= 1'b0;
      end
      // reply under way; clearing the count stops a second auto-start
      else if (state_reg == srpf_pkg::SRPF_FL_HDR)
         fwr_reg <= 9'h000;
   end
   always_ff @(posedge SYS_CLK)
   begin
      if (fill_reg && FLASH_IN_VALID)
         fbuf[fwr_reg] <= FLASH_IN_BYTE;
   end

   // histogram accumulates the pixels of each column as it goes out
   logic [3:0] pix [0:7];
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pix[i] = 4'h0;
         unique case (depth_reg)
            srpf_pkg::SRPF_DEPTH_G4: pix[i] = COL_DATA[i*4 +: 4];
            srpf_pkg::SRPF_DEPTH_G2: pix[i] = {2'b00, COL_DATA[i*2 +: 2]};
            default: pix[i] = {3'b000, COL_DATA[i]};
         endcase
      end
   end
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_hist
         logic [3:0] hits;
         always_comb
         begin
            hits = 4'h0;
            for (int i = 0; i < 8; i++)
               hits = hits + {3'b000, pix[i] == 4'(gi)};
         end
         always_ff @(posedge SYS_CLK or negedge RST_N)
         begin
            if (!RST_N)
               hist_reg[gi] <= 8'h00;
            else if (state_reg == srpf_pkg::SRPF_IMG_HDR && take)
               hist_reg[gi] <= 8'h00;
            else if (state_reg == srpf_pkg::SRPF_IMG_COL && take &&
                     sub_reg == 2'(col_bytes - 3'h1) &&
                     hist_reg[gi] + {4'h0, hits} <= `SRPF_BIN_MAX)
               hist_reg[gi] <= hist_reg[gi] + {4'h0, hits};
         end
      end
   endgenerate

   // message sequencer
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_reg <= srpf_pkg::SRPF_IDLE;
         cnt_reg <= 9'h000;
         sub_reg <= 2'b00;
         depth_reg <= 2'b00;
         hist_en_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            srpf_pkg::SRPF_IDLE:
            begin
               cnt_reg <= 9'h000;
               sub_reg <= 2'b00;
               if (START_IMAGE && NAV_MODE)
                  state_reg <= srpf_pkg::SRPF_NAV_HDR;
               else if (START_IMAGE)
               begin
                  depth_reg <= (PIX_DEPTH == 2'b11) ? 2'b10 : PIX_DEPTH;
                  hist_en_reg <= HIST_EN;
                  state_reg <= srpf_pkg::SRPF_IMG_HDR;
               end
               else if (REG_READ)
                  state_reg <= srpf_pkg::SRPF_REG_HDR;
               else if (flen_reg != 9'h000 && !fill_reg && fwr_reg == flen_reg)
                  state_reg <= srpf_pkg::SRPF_FL_HDR;
            end
            srpf_pkg::SRPF_IMG_HDR:
               if (take)
                  state_reg <= srpf_pkg::SRPF_IMG_COL;
            srpf_pkg::SRPF_IMG_COL:
               if (take)
               begin
                  if (sub_reg == 2'(col_bytes - 3'h1))
                  begin
                     sub_reg <= 2'b00;
                     cnt_reg <= cnt_reg + 9'h001;
                     if (cnt_reg == {1'b0, `SRPF_COLS} - 9'h001)
                     begin
                        cnt_reg <= 9'h000;
                        state_reg <= hist_en_reg ? srpf_pkg::SRPF_HIST_HDR :
                           srpf_pkg::SRPF_AUTH_HDR;
                     end
                  end
                  else
                     sub_reg <= sub_reg + 2'b01;
               end
            srpf_pkg::SRPF_HIST_HDR:
               if (take)
                  state_reg <= srpf_pkg::SRPF_HIST_BIN;
            srpf_pkg::SRPF_HIST_BIN:
               if (take)
               begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (cnt_reg[3:0] == nbins)
                  begin
                     cnt_reg <= 9'h000;
                     state_reg <= srpf_pkg::SRPF_AUTH_HDR;
                  end
               end
            srpf_pkg::SRPF_AUTH_HDR:
               if (take)
                  state_reg <= srpf_pkg::SRPF_AUTH_DAT;
            srpf_pkg::SRPF_AUTH_DAT:
               if (take)
               begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (cnt_reg == 9'h003)
                     state_reg <= srpf_pkg::SRPF_IDLE;
               end
            srpf_pkg::SRPF_REG_HDR:
               if (take)
                  state_reg <= srpf_pkg::SRPF_REG_PAIR;
            srpf_pkg::SRPF_REG_PAIR:
               if (take)
               begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (cnt_reg == {4'h0, `SRPF_NUM_REGS, 1'b0} - 9'h001)
                     state_reg <= srpf_pkg::SRPF_IDLE;
               end
            srpf_pkg::SRPF_FL_HDR:
               if (take)
               begin
                  sub_reg <= sub_reg + 2'b01;
                  if (sub_reg == 2'b01)
                  begin
                     sub_reg <= 2'b00;
                     state_reg <= srpf_pkg::SRPF_FL_DAT;
                  end
               end
            srpf_pkg::SRPF_FL_DAT:
               if (take)
               begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (cnt_reg == flen_reg - 9'h001)
                     state_reg <= srpf_pkg::SRPF_IDLE;
               end
            srpf_pkg::SRPF_NAV_HDR:
               if (take)
                  state_reg <= srpf_pkg::SRPF_NAV_DAT;
            srpf_pkg::SRPF_NAV_DAT:
               if (take)
               begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (cnt_reg == 9'h001)
                     state_reg <= srpf_pkg::SRPF_IDLE;
               end
            default:
               state_reg <= srpf_pkg::SRPF_IDLE;
         endcase
      end
   end

   // byte selection; the second flash header byte carries only length bit 8
   always_comb
   begin
      src_valid = 1'b1;
      src_byte.last = 1'b0;
      src_byte.data = 8'h00;
      unique case (state_reg)
         srpf_pkg::SRPF_IMG_HDR: src_byte.data = `SRPF_HDR_IMAGE;
         srpf_pkg::SRPF_IMG_COL: src_byte.data = col_byte;
         srpf_pkg::SRPF_HIST_HDR: src_byte.data = `SRPF_HDR_HIST;
         srpf_pkg::SRPF_HIST_BIN: src_byte.data = hist_reg[cnt_reg[3:0]];
         srpf_pkg::SRPF_AUTH_HDR: src_byte.data = `SRPF_HDR_AUTH;
         srpf_pkg::SRPF_AUTH_DAT:
         begin
            src_byte.data = AUTH_WORD[{cnt_reg[1:0], 3'h0} +: 8];
            src_byte.last = (cnt_reg == 9'h003);
         end
         srpf_pkg::SRPF_REG_HDR: src_byte.data = `SRPF_HDR_REG;
         srpf_pkg::SRPF_REG_PAIR:
         begin
            src_byte.data = cnt_reg[0] ? regs_reg[cnt_reg[3:1]] :
               {5'h00, cnt_reg[3:1]};
            src_byte.last = (cnt_reg == {4'h0, `SRPF_NUM_REGS, 1'b0} - 9'h001);
         end
         srpf_pkg::SRPF_FL_HDR:
            src_byte.data = (sub_reg == 2'b00) ? `SRPF_HDR_FLASH :
               {7'h00, flen_reg[8]};
         srpf_pkg::SRPF_FL_DAT:
         begin
            src_byte.data = flash_byte;
            src_byte.last = (cnt_reg == flen_reg - 9'h001);
         end
         srpf_pkg::SRPF_NAV_HDR: src_byte.data = `SRPF_HDR_NAV;
         srpf_pkg::SRPF_NAV_DAT:
         begin
            src_byte.data = NAV_DATA[{cnt_reg[0], 3'h0} +: 8];
            src_byte.last = (cnt_reg == 9'h001);
         end
         default: src_valid = 1'b0;
      endcase
   end

   // two-entry skid buffer; a stall by the usb side loses no byte
   srpf_pkg::srpf_byte_t buf_reg [0:1];
   logic [1:0] cnt_buf_reg;
   logic pop;
   assign pop = OUT_VALID && OUT_READY;
   assign src_ready = (cnt_buf_reg != 2'h2);
   assign OUT_VALID = (cnt_buf_reg != 2'h0);
   assign OUT_DATA = buf_reg[0].data;
   assign OUT_LAST = buf_reg[0].last;
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cnt_buf_reg <= 2'h0;
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
      end
      else
      begin
         if (pop)
            buf_reg[0] <= buf_reg[1];
         if (take)
         begin
            if (cnt_buf_reg == 2'h0 || (cnt_buf_reg == 2'h1 && pop))
               buf_reg[0] <= src_byte;
            else
               buf_reg[(cnt_buf_reg == 2'h2 || pop) ? 0 : 1] <= src_byte;
         end
         cnt_buf_reg <= cnt_buf_reg + {1'b0, take} - {1'b0, pop};
      end
   end

   hdr_first_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      state_reg == srpf_pkg::SRPF_IDLE && START_IMAGE && !NAV_MODE |=>
      state_reg == srpf_pkg::SRPF_IMG_HDR && src_byte.data == `SRPF_HDR_IMAGE)
      else $error("image message lacks header");
   bin_cap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      state_reg == srpf_pkg::SRPF_HIST_BIN |-> src_byte.data <= `SRPF_BIN_MAX)
      else $error("bin over limit");
   hist_skip_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !hist_en_reg |-> state_reg != srpf_pkg::SRPF_HIST_HDR)
      else $error("histogram sent while disabled");
   pass_cmd_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CMD_VALID |=> FLASH_CMD_VALID && FLASH_CMD_BYTE == $past(CMD_BYTE))
      else $error("flash command altered");
   auth_after_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      state_reg == srpf_pkg::SRPF_AUTH_HDR |->
      $past(state_reg) inside {srpf_pkg::SRPF_AUTH_HDR, srpf_pkg::SRPF_IMG_COL,
      srpf_pkg::SRPF_HIST_BIN}) else $error("auth not after image");
   reg_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      regs_reg[1][7:4] == 4'h0) else $error("reserved bits set");
   reg_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      REG_WR_VALID && REG_WR_ADDR == 8'h00 |=> regs_reg[0] == $past(REG_WR_DATA))
      else $error("register write lost");
   nav_hdr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      state_reg == srpf_pkg::SRPF_IDLE && START_IMAGE && NAV_MODE |=>
      state_reg == srpf_pkg::SRPF_NAV_HDR) else $error("nav packet not chosen");
   cv_image: cover property (@(posedge SYS_CLK) state_reg == srpf_pkg::SRPF_AUTH_DAT);
   cv_stall: cover property (@(posedge SYS_CLK) cnt_buf_reg == 2'h2);
   cv_flash: cover property (@(posedge SYS_CLK) state_reg == srpf_pkg::SRPF_FL_DAT);
endmodule : srpf_framer
`default_nettype wire

// *** srpf_host_model.sv ***
// Purpose: usb host side sink for the reply byte stream of the framer
// Assumes: one byte taken per rising edge while valid and ready are high
// Notes: stalls come from $urandom so they follow the bench seed
`default_nettype none
module srpf_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall_en,
   input wire logic [7:0] data,
   input wire logic last,
   input wire logic valid,
   output logic ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] got[$];
   // ready moves only off the sampling edge, so the framer must hold its byte
   always @(negedge clk)
      ready <= rst_n && (!stall_en || $urandom_range(3) != 0);
   // bytes kept in arrival order; messages found by length, not header value
   always @(posedge clk)
      if (rst_n && valid && ready)
         got.push_back({last, data});
endmodule : srpf_host_model
`default_nettype wire

// *** sensor_reply_packet_framer_bench.sv ***
// Purpose: self-checking bench for the reply packet framer
// Assumes: inputs change on the falling edge, seed fixed
// Notes: expected streams are rebuilt from the pixel memory and header codes
`include "srpf_defs.svh"
`default_nettype none
module sensor_reply_packet_framer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic SYS_CLK, RST_N, START_IMAGE, NAV_MODE, HIST_EN, REG_READ, REG_WR_VALID, CMD_VALID;
   logic FLASH_RD_START, FLASH_IN_VALID, FLASH_IN_READY, FLASH_CMD_VALID;
   logic OUT_LAST, OUT_VALID, OUT_READY, BUSY, stall;
   logic [1:0] PIX_DEPTH;
   logic [31:0] COL_DATA, AUTH_WORD;
   logic [15:0] NAV_DATA;
   logic [6:0] COL_INDEX;
   logic [7:0] REG_WR_ADDR, REG_WR_DATA, CMD_BYTE, FLASH_CMD_BYTE, FLASH_IN_BYTE, OUT_DATA;
   logic [63:0] REG_FILE;
   logic [8:0] FLASH_RD_LEN;
   logic [31:0] cols [128];
   logic [7:0] regs [8];
   logic [8:0] exp_q[$];
   int fails, n_checks;
   assign COL_DATA = cols[COL_INDEX];

   srpf_framer srpf_framer_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .START_IMAGE(START_IMAGE),
      .NAV_MODE(NAV_MODE), .HIST_EN(HIST_EN), .PIX_DEPTH(PIX_DEPTH), .COL_DATA(COL_DATA),
      .COL_INDEX(COL_INDEX), .AUTH_WORD(AUTH_WORD), .NAV_DATA(NAV_DATA), .REG_READ(REG_READ),
      .REG_WR_VALID(REG_WR_VALID), .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA),
      .REG_FILE(REG_FILE), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE),
      .FLASH_CMD_VALID(FLASH_CMD_VALID), .FLASH_CMD_BYTE(FLASH_CMD_BYTE),
      .FLASH_RD_START(FLASH_RD_START), .FLASH_RD_LEN(FLASH_RD_LEN),
      .FLASH_IN_VALID(FLASH_IN_VALID), .FLASH_IN_BYTE(FLASH_IN_BYTE),
      .FLASH_IN_READY(FLASH_IN_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
      .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .BUSY(BUSY));

   srpf_host_model srpf_host_model_inst (.clk(SYS_CLK), .rst_n(RST_N), .stall_en(stall),
      .data(OUT_DATA), .last(OUT_LAST), .valid(OUT_VALID), .ready(OUT_READY));

   initial
   begin
      SYS_CLK = 1'b0;
      forever #50 SYS_CLK = ~SYS_CLK;
   end

   // about 2.5k cycles expected; 30k cycles, some twelve times that, before giving up
   initial
   begin
      #3000000;
      fails++;
      final_report();
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic expect_stream(input string name);
      int i;
      i = 0;
      while (srpf_host_model_inst.got.size() < exp_q.size() && i < 5000)
      begin
         @(negedge SYS_CLK);
         i++;
      end
      // extra cycles catch a stray trailing or refused message
      repeat (12) @(negedge SYS_CLK);
      chk(BUSY, 1'b0);
      chk(srpf_host_model_inst.got.size(), exp_q.size());
      foreach (exp_q[j])
         if (j < srpf_host_model_inst.got.size())
            chk(srpf_host_model_inst.got[j], exp_q[j]);
      srpf_host_model_inst.got.delete();
      exp_q.delete();
      $display("test %s done, mismatches so far %0d", name, fails);
   endtask : expect_stream

   task automatic exp_image(input logic [1:0] d, input logic h, input logic [31:0] aw);
      int w;
      int cnt[16];
      int hit[16];
      w = (d == 2'b00) ? 1 : (d == 2'b01) ? 2 : 4;
      foreach (cnt[i])
         cnt[i] = 0;
      exp_q.push_back({1'b0, `SRPF_HDR_IMAGE});
      for (int c = 0; c < 128; c++)
      begin
         for (int b = 0; b < w; b++)
            exp_q.push_back({1'b0, cols[c][8*b +: 8]});
         foreach (hit[i])
            hit[i] = 0;
         for (int p = 0; p < 8; p++)
            hit[(cols[c] >> (p * w)) & ((1 << w) - 1)]++;
         // a column that would push a bin past 128 is left out of that bin
         foreach (hit[i])
            if (cnt[i] + hit[i] <= 128)
               cnt[i] += hit[i];
      end
      if (h)
      begin
         exp_q.push_back({1'b0, `SRPF_HDR_HIST});
         for (int b = 0; b < (1 << w); b++)
            exp_q.push_back({1'b0, 8'(cnt[b])});
      end
      exp_q.push_back({1'b0, `SRPF_HDR_AUTH});
      for (int b = 0; b < 4; b++)
         exp_q.push_back({b == 3, aw[8*b +: 8]});
   endtask : exp_image

   initial
   begin
      logic [7:0] b8;
      logic [8:0] len;
      void'($urandom(32'h3704BBA8));
      {RST_N, START_IMAGE, NAV_MODE, HIST_EN, REG_READ, REG_WR_VALID, CMD_VALID} = 7'h00;
      {FLASH_RD_START, FLASH_IN_VALID, stall, PIX_DEPTH} = 5'h00;
      {AUTH_WORD, NAV_DATA, REG_WR_ADDR, REG_WR_DATA, CMD_BYTE} = 72'h0;
      {FLASH_IN_BYTE, FLASH_RD_LEN} = 17'h0;
      fails = 0;
      n_checks = 0;
      foreach (cols[c])
         cols[c] = $urandom;
      repeat (16) @(negedge SYS_CLK);
      RST_N = 1'b1;
      @(negedge SYS_CLK);
      // register writes back to back, then a full dump under stalls
      for (int a = 0; a < 8; a++)
      begin
         REG_WR_VALID = 1'b1;
         REG_WR_ADDR = 8'(a);
         REG_WR_DATA = $urandom;
         regs[a] = REG_WR_DATA & ((a % 2) ? `SRPF_REG_MASK1 : `SRPF_REG_MASK0);
         @(negedge SYS_CLK);
      end
      REG_WR_VALID = 1'b0;
      for (int a = 0; a < 8; a++)
         chk(REG_FILE[8*a +: 8], regs[a]);
      stall = 1'b1;
      REG_READ = 1'b1;
      @(negedge SYS_CLK);
      REG_READ = 1'b0;
      exp_q.push_back({1'b0, `SRPF_HDR_REG});
      for (int a = 0; a < 8; a++)
      begin
         exp_q.push_back({1'b0, 8'(a)});
         exp_q.push_back({a == 7, regs[a]});
      end
      expect_stream("register dump");
      // every pixel depth, depth code 3 included, histogram on and off
      for (int t = 0; t < 5; t++)
      begin
         foreach (cols[c])
            cols[c] = $urandom;
         PIX_DEPTH = (t == 4) ? 2'b11 : 2'(t % 3);
         HIST_EN = (t < 3);
         AUTH_WORD = $urandom;
         stall = t[0];
         START_IMAGE = 1'b1;
         @(negedge SYS_CLK);
         START_IMAGE = 1'b0;
         // histogram choice is taken at start, so flipping it now must not matter
         chk(BUSY, 1'b1);
         HIST_EN = ~HIST_EN;
         exp_image(PIX_DEPTH, t < 3, AUTH_WORD);
         if (t == 2)
         begin
            repeat (20) @(negedge SYS_CLK);
            REG_READ = 1'b1;
            @(negedge SYS_CLK);
            REG_READ = 1'b0;
         end
         expect_stream("image");
      end
      // navigation mode gives the short packet instead of an image
      NAV_MODE = 1'b1;
      NAV_DATA = $urandom;
      START_IMAGE = 1'b1;
      @(negedge SYS_CLK);
      START_IMAGE = 1'b0;
      exp_q.push_back({1'b0, `SRPF_HDR_NAV});
      exp_q.push_back({1'b0, NAV_DATA[7:0]});
      exp_q.push_back({1'b1, NAV_DATA[15:8]});
      expect_stream("navigation");
      NAV_MODE = 1'b0;
      // flash reads: shortest length and one that needs length bit 8
      for (int t = 0; t < 2; t++)
      begin
         len = t ? 9'h104 : 9'h001;
         stall = 1'b1;
         FLASH_RD_LEN = len;
         FLASH_RD_START = 1'b1;
         @(negedge SYS_CLK);
         FLASH_RD_START = 1'b0;
         exp_q.push_back({1'b0, `SRPF_HDR_FLASH});
         exp_q.push_back({1'b0, 7'h00, len[8]});
         for (int i = 0; i < len; i++)
         begin
            FLASH_IN_VALID = 1'b1;
            FLASH_IN_BYTE = $urandom;
            exp_q.push_back({i == len - 1, FLASH_IN_BYTE});
            while (FLASH_IN_READY !== 1'b1)
               @(negedge SYS_CLK);
            @(negedge SYS_CLK);
         end
         FLASH_IN_VALID = 1'b0;
         expect_stream("flash read");
      end
      // flash commands pass straight through, one cycle behind
      for (int k = 0; k < 4; k++)
      begin
         CMD_VALID = 1'b1;
         CMD_BYTE = $urandom;
         b8 = CMD_BYTE;
         @(negedge SYS_CLK);
         chk({FLASH_CMD_VALID, FLASH_CMD_BYTE}, {1'b1, b8});
      end
      CMD_VALID = 1'b0;
      @(negedge SYS_CLK);
      chk(FLASH_CMD_VALID, 1'b0);
      $display("test flash passthrough done, mismatches so far %0d", fails);
      final_report();
   end
endmodule : sensor_reply_packet_framer_bench
`default_nettype wire
